// *** hdl/aish_defs.svh ***
// Constants for the analog input smoothing and hysteresis block.
// Assumes samples are unsigned codes; volts map to codes by a fixed scale.
`ifndef AISH_DEFS_SVH
`define AISH_DEFS_SVH
`define AISH_ORDER_MAX    5'd16
`define AISH_ORDER_RESET  5'd3
`define AISH_CODE_PER_10V 32'd65535
`define AISH_HYST_MAX     `AISH_CODE_PER_10V
`define AISH_HYST_RESET   (`AISH_CODE_PER_10V / 32'd1000)
`define AISH_FRAC_BITS    16
`endif

// *** hdl/aish_pkg.sv ***
// Types for the analog input smoothing and hysteresis block.
// Assumes aish_defs.svh is included by the users of the constants.
package aish_pkg;
  typedef logic [4:0] aish_order_t;
endpackage

// *** hdl/aish_fifo.sv ***
// Small valid/ready FIFO in flip-flops.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module aish_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             srst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      $error("aish_fifo: DEPTH must be a power of two of at least 2");
  end
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
  } aish_fifo_s;
  aish_fifo_s st_reg, st_next;
  logic push, pop;
  // Full at DEPTH entries; the count is one bit wider than the index
  assign in_ready  = st_reg.cnt < (AW+1)'(DEPTH);
  assign out_valid = st_reg.cnt != '0;
  assign out_data  = st_reg.mem[st_reg.rd];
  assign push = in_valid && in_ready;
  assign pop  = out_valid && out_ready;
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wr] = in_data;
      st_next.wr = st_reg.wr + 1'b1;
    end
    if (pop)
      st_next.rd = st_reg.rd + 1'b1;
    if (push && !pop)
      st_next.cnt = st_reg.cnt + 1'b1;
    else if (pop && !push)
      st_next.cnt = st_reg.cnt - 1'b1;
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule // aish_fifo

// *** hdl/aish_top.sv ***
// Per-channel lowpass smoothing then hysteresis on analog samples.
// Assumes samples arrive with a channel index, synchronous to mclk.
`timescale 1ns/1ps
`include "aish_defs.svh"
module aish_top #(
  parameter int CHANNELS = 4,
  parameter int SWIDTH   = 16,
  parameter int DEPTH    = 8
) (
  input  wire logic                        mclk,
  input  wire logic                        srst,
  input  wire aish_pkg::aish_order_t       smoothing_order_setting,
  input  wire logic [SWIDTH-1:0]           hyst_amount,
  input  wire logic                        hyst_load,
  input  wire logic                        samp_valid,
  output logic                             samp_ready,
  input  wire logic [$clog2(CHANNELS)-1:0] samp_chan,
  input  wire logic [SWIDTH-1:0]           samp_data,
  output logic                             out_valid,
  input  wire logic                        out_ready,
  output logic [$clog2(CHANNELS)-1:0]      out_chan,
  output logic [SWIDTH-1:0]                out_data,
  output logic [CHANNELS-1:0][SWIDTH-1:0]  active_value,
  output aish_pkg::aish_order_t            order_active,
  output logic [SWIDTH-1:0]                hyst_active
);
  localparam int CW = $clog2(CHANNELS);
  localparam int FB = `AISH_FRAC_BITS;
  localparam int AW = SWIDTH + FB;
  initial begin
    if (CHANNELS < 2 || SWIDTH < 8 || SWIDTH > 32)
      $error("aish_top: CHANNELS >= 2 and SWIDTH 8..32 needed");
  end

  typedef struct packed {
    logic [CHANNELS-1:0][AW-1:0]     acc;
    logic [CHANNELS-1:0][SWIDTH-1:0] ref_v;
    logic [CHANNELS-1:0]             primed;
    aish_pkg::aish_order_t           order;
    logic [SWIDTH-1:0]               hyst;
  } aish_top_s;
  aish_top_s st_reg, st_next;

  // Absolute distance, used for both window edges
  function automatic logic [SWIDTH-1:0] absdiff(
    input logic [SWIDTH-1:0] a,
    input logic [SWIDTH-1:0] b
  );
    absdiff = (a > b) ? a - b : b - a;
  endfunction

  logic              fifo_in_ready;
  logic              take;
  logic              emit;
  logic [AW-1:0]     acc_cur;
  logic [AW-1:0]     acc_new;
  logic [AW-1:0]     x_ext;
  logic [SWIDTH-1:0] filt;
  logic [SWIDTH-1:0] rnd_ref;
  logic [SWIDTH-1:0] hyst_sat;

  // Stall the source while the readout FIFO is full
  assign samp_ready = fifo_in_ready;
  assign take       = samp_valid && samp_ready;
  assign acc_cur    = st_reg.acc[samp_chan];
  assign x_ext      = {samp_data, {FB{1'b0}}};
  // Keeping fractional bits lets high orders still move the output
  assign acc_new    = acc_cur - (acc_cur >>> st_reg.order)
                      + (x_ext >>> st_reg.order);
  assign hyst_sat   = (32'(hyst_amount) > `AISH_HYST_MAX) ?
                      SWIDTH'(`AISH_HYST_MAX) : hyst_amount;

  always_comb begin
    st_next = st_reg;
    filt    = samp_data;
    emit    = 1'b0;
    rnd_ref = st_reg.ref_v[samp_chan];
    if (hyst_load)
      st_next.hyst = hyst_sat;
    if (smoothing_order_setting <= `AISH_ORDER_MAX &&
        smoothing_order_setting != st_reg.order) begin
      st_next.order  = smoothing_order_setting;
      st_next.primed = '0;
    end else if (take) begin
      if (!st_reg.primed[samp_chan]) begin
        st_next.acc[samp_chan]    = x_ext;
        st_next.ref_v[samp_chan]  = samp_data;
        st_next.primed[samp_chan] = 1'b1;
        emit = 1'b1;
      end else begin
        filt = acc_new[AW-1:FB];
        st_next.acc[samp_chan] = acc_new;
        if (absdiff(filt, rnd_ref) > st_reg.hyst) begin
          st_next.ref_v[samp_chan] = filt;
          emit = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_reg       <= '0;
      st_reg.order <= `AISH_ORDER_RESET;
      st_reg.hyst  <= SWIDTH'(`AISH_HYST_RESET);
    end else begin
      st_reg <= st_next;
    end
  end

  assign active_value = st_reg.ref_v;
  assign order_active = st_reg.order;
  assign hyst_active  = st_reg.hyst;

  aish_fifo #(.WIDTH(CW + SWIDTH), .DEPTH(DEPTH)) u_fifo (
    .mclk      (mclk),
    .srst      (srst),
    .in_valid  (emit),
    .in_ready  (fifo_in_ready),
    .in_data   ({samp_chan, filt}),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  ({out_chan, out_data})
  );

  chk_order_reset: assert property (@(posedge mclk)
    $fell(srst) |-> order_active == `AISH_ORDER_RESET)
    else $error("order not at reset value");
  chk_order_range: assert property (@(posedge mclk) disable iff (srst)
    order_active <= `AISH_ORDER_MAX)
    else $error("order out of range");
  chk_hyst_reset: assert property (@(posedge mclk)
    $fell(srst) |-> hyst_active == SWIDTH'(`AISH_HYST_RESET))
    else $error("hysteresis not at reset value");
  chk_drop_inside: assert property (@(posedge mclk) disable iff (srst)
    take && st_reg.primed[samp_chan] &&
    absdiff(filt, rnd_ref) <= st_reg.hyst |-> !emit)
    else $error("inside sample emitted");
  chk_ref_update: assert property (@(posedge mclk) disable iff (srst)
    emit && st_reg.primed[samp_chan] && !hyst_load |=>
    active_value[$past(samp_chan)] == $past(filt))
    else $error("reference not updated");
  chk_prime_load: assert property (@(posedge mclk) disable iff (srst)
    take && !st_reg.primed[samp_chan] && st_next.order == st_reg.order
    |=> active_value[$past(samp_chan)] == $past(samp_data))
    else $error("first sample not loaded");
  chk_order_zero: assert property (@(posedge mclk) disable iff (srst)
    take && st_reg.order == 5'h0 && st_reg.primed[samp_chan]
    |-> filt == samp_data)
    else $error("order zero not pass-through");
  chk_fifo_stall: assert property (@(posedge mclk) disable iff (srst)
    !samp_ready |-> !emit)
    else $error("emit while stalled");
endmodule // aish_top

// *** tb/aish_partner.sv ***
// Sample source and readout sink around the smoothing block.
// Assumes rising-edge timing on mclk and valid/ready handshakes.
`timescale 1ns/1ps
module aish_partner (
  input  wire logic        mclk,
  input  wire logic        stall,
  output logic             samp_valid,
  input  wire logic        samp_ready,
  output logic [1:0]       samp_chan,
  output logic [15:0]      samp_data,
  input  wire logic        out_valid,
  output logic             out_ready,
  input  wire logic [1:0]  out_chan,
  input  wire logic [15:0] out_data
);
  logic [17:0] got_q[$];
  initial begin
    samp_valid = 1'b0;
    samp_chan  = 2'h0;
    samp_data  = 16'h0000;
    out_ready  = 1'b0;
  end
  always @(posedge mclk) begin
    out_ready <= ~stall;
    if (out_valid && out_ready)
      got_q.push_back({out_chan, out_data});
  end
  // Released data is inverted so stale values never pass
  task automatic send(input logic [1:0] c, input logic [15:0] d);
    logic r;
    @(posedge mclk);
    samp_valid <= 1'b1;
    samp_chan  <= c;
    samp_data  <= d;
    do begin
      @(negedge mclk) r = samp_ready;
      @(posedge mclk);
    end while (!r);
    samp_valid <= 1'b0;
    samp_data  <= ~d;
  endtask
  task automatic fill(output int n);
    logic r;
    n = 0;
    @(posedge mclk);
    samp_valid <= 1'b1;
    samp_chan  <= 2'h2;
    samp_data  <= 16'h0000;
    forever begin
      @(negedge mclk) r = samp_ready;
      @(posedge mclk);
      if (!r || n > 20) break;
      n++;
      samp_data <= ~samp_data;
    end
    samp_valid <= 1'b0;
  endtask
endmodule // aish_partner

// *** tb/aish_top_bench.sv ***
// Self-checking bench for the smoothing and hysteresis block.
// Assumes the partner model drives samples and sinks the output.
`timescale 1ns/1ps
module aish_top_bench;
  logic mclk, srst, hyst_load, samp_valid, samp_ready, out_valid;
  logic out_ready, stall;
  logic [4:0]       order_set, order_act;
  logic [15:0]      hyst_amount, hyst_act, samp_data, out_data;
  logic [1:0]       samp_chan, out_chan;
  logic [3:0][15:0] active;
  int miscompares = 0, checked = 0, cycles = 0, n;
  aish_top #(.CHANNELS(4), .SWIDTH(16), .DEPTH(8)) dut_u (.mclk(mclk),
    .srst(srst), .smoothing_order_setting(order_set),
    .hyst_amount(hyst_amount), .hyst_load(hyst_load),
    .samp_valid(samp_valid), .samp_ready(samp_ready),
    .samp_chan(samp_chan), .samp_data(samp_data), .out_valid(out_valid),
    .out_ready(out_ready), .out_chan(out_chan), .out_data(out_data),
    .active_value(active), .order_active(order_act),
    .hyst_active(hyst_act));
  aish_partner p_u (.mclk(mclk), .stall(stall), .samp_valid(samp_valid),
    .samp_ready(samp_ready), .samp_chan(samp_chan),
    .samp_data(samp_data), .out_valid(out_valid), .out_ready(out_ready),
    .out_chan(out_chan), .out_data(out_data));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic final_report;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Ceiling well above the hundred or so cycles the run needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic check(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic expect_out(input logic [1:0] c, input logic [15:0] d);
    logic [17:0] v;
    v = 18'h3FFFF;
    repeat (10) if (p_u.got_q.size() == 0) @(posedge mclk);
    if (p_u.got_q.size() != 0) v = p_u.got_q.pop_front();
    check("out", v, {c, d});
  endtask
  task automatic expect_none;
    repeat (5) @(posedge mclk);
    check("drop", p_u.got_q.size(), 0);
  endtask
  task automatic set_cfg(input logic [4:0] o, input logic ld,
                         input logic [15:0] h);
    @(posedge mclk);
    order_set   <= o;
    hyst_load   <= ld;
    hyst_amount <= h;
    @(posedge mclk);
    hyst_load <= 1'b0;
    @(negedge mclk);
  endtask
  task automatic t_filter;
    p_u.send(2'h0, 16'h03E8);
    expect_out(2'h0, 16'h03E8);
    check("ref0", active[0], 16'h03E8);
    p_u.send(2'h1, 16'h1388);
    expect_out(2'h1, 16'h1388);
    p_u.send(2'h0, 16'h0708);
    expect_out(2'h0, 16'h044C);
    p_u.send(2'h0, 16'h044C);
    expect_none();
  endtask
  task automatic t_order0;
    set_cfg(5'h11, 1'b0, 16'h0000);
    check("order", order_act, 5'h03);
    set_cfg(5'h00, 1'b0, 16'h0000);
    p_u.send(2'h0, 16'h0BB8);
    expect_out(2'h0, 16'h0BB8);
    p_u.send(2'h0, 16'h0BF9);
    expect_none();
    p_u.send(2'h0, 16'h0BFA);
    expect_out(2'h0, 16'h0BFA);
    set_cfg(5'h00, 1'b1, 16'hFFFF);
    check("hyst", hyst_act, 16'hFFFF);
    p_u.send(2'h0, 16'h0000);
    expect_none();
    set_cfg(5'h00, 1'b1, 16'h0000);
    p_u.send(2'h0, 16'h0001);
    expect_out(2'h0, 16'h0001);
  endtask
  task automatic t_fill;
    stall <= 1'b1;
    p_u.fill(n);
    check("full", n >= 8, 1);
    stall <= 1'b0;
    repeat (30) @(posedge mclk);
    check("drained", p_u.got_q.size(), n);
  endtask
  initial begin
    {srst, stall, hyst_load, hyst_amount} = {1'b1, 1'b0, 1'b0, 16'h0000};
    order_set = 5'h03;
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    @(negedge mclk);
    check("order_rst", order_act, 5'h03);
    check("hyst_rst", hyst_act, 16'h0041);
    check("idle", out_valid, 1'b0);
    t_filter();
    t_order0();
    t_fill();
    final_report();
  end
endmodule // aish_top_bench
